// ===== hw/ssr_map.svh
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_STB_RAMP 7
`define SSR_STB_RQS 6
`define SSR_STB_ESB 5
`define SSR_STB_ERR 4
`define SSR_STB_ALM 3
`define SSR_STB_VALID 2
`define SSR_STB_LATCH_MASK 8'hbc
`define SSR_ESR_PON 7
`define SSR_ESR_CME 5
`define SSR_ESR_EXE 4
`define SSR_ESR_QYE 2
`define SSR_ESR_OPC 0
`define SSR_ESR_USED_MASK 8'hb5
`define SSR_ZERO_BYTE 8'h00
`define SSR_ERR_SRC_W 8
`define SSR_Q_NONE 3'h0
`define SSR_Q_STB 3'h1
`define SSR_Q_SRE 3'h2
`define SSR_Q_ESR 3'h3
`define SSR_Q_ESE 3'h4
`define SSR_Q_DATA 3'h5
`endif

// ===== hw/ssr_pkg.sv
package ssr_pkg;
  typedef enum logic [2:0] {
    SSR_Q_NONE_E = 3'h0,
    SSR_Q_STB_E = 3'h1,
    SSR_Q_SRE_E = 3'h2,
    SSR_Q_ESR_E = 3'h3,
    SSR_Q_ESE_E = 3'h4,
    SSR_Q_DATA_E = 3'h5
  } ssr_query_t;
  typedef enum logic [1:0] {
    SSR_IDLE = 2'b00,
    SSR_ARMED = 2'b01,
    SSR_SEND = 2'b11
  } ssr_state_t;
endpackage

// ===== hw/ssr_status_service_request.sv
`timescale 1ns/1ps
`include "ssr_map.svh"
// Functional notes
// - Response goes out only while addressed as talker; query never starts it.
// - Several pending queries: only the most recent one is answered.
// - Status byte has eight bits; bits 7..2 defined, bits 1 and 0 zero.
// - Service requests enabled and enabled status bit set drives SRQ low.
// - Serial poll returns status byte, then clears its latched bits.
// - Each service request mask bit except bit 6 enables its status report when one.
// - Service request only when mask bit 6 is set.
// - With requests disabled, serial polls still answer; SRQ never asserted.
// - Status byte query returns contents without clearing bits.
// - Ramp completion sets status bit 7.
// - Any event register bit set whose event enable mask bit is set makes status bit 5 set.
// - Any of eight instrument error sources sets status bit 4.
// - Alarm condition sets bit 3; each valid reading sets bit 2.
// - Event register holds bits 7,5,4,2,0; bits 1,3,6 read zero.
// - Events interrupt only when enabled and mask bit 5 set.
// - Event enable register loads the written weighting sum as mask.
// - Enable query returns enable mask; event query returns and clears.
// - Power-on sets event bit 7.
// - Uninterpretable command sets event bit 5.
// - Command beyond capabilities sets event bit 4.
// - Response lost to full output queue sets event bit 2.
// - After operation-complete command, bit 0 sets once operations finish.
module ssr_status_service_request (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Instrument events, same clock domain
  input wire logic ramp_done_in,
  input wire logic [7:0] instr_error_in,
  input wire logic alarm_in,
  input wire logic valid_read_in,
  input wire logic cmd_error_in,
  input wire logic exec_error_in,
  input wire logic query_lost_in,
  input wire logic opc_cmd_in,
  input wire logic ops_pending_in,
  // Decoded commands and queries
  input wire logic sre_write_in,
  input wire logic ese_write_in,
  input wire logic [7:0] wr_data_in,
  input wire logic query_valid_in,
  input wire logic [2:0] query_sel_in,
  input wire logic [7:0] query_data_in,
  // Bus state, from the bus pins
  input wire logic talk_addr_in,
  input wire logic serial_poll_in,
  input wire logic resp_taken_in,
  // Response and poll byte
  output logic resp_valid_out,
  output logic [7:0] resp_data_out,
  output logic [7:0] poll_byte_out,
  // Open-drain SRQ: enable low while pulling the line low
  output logic srq_o_out,
  output logic srq_oe_n_out
);
  logic rst_s1_reg, rst_n_reg;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // Bus lines come from pins, so two flops before use
  logic [2:0] bus_s1_reg, bus_s2_reg;
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bus_s1_reg <= 3'h0;
      bus_s2_reg <= 3'h0;
    end else begin
      bus_s1_reg <= {talk_addr_in, serial_poll_in, resp_taken_in};
      bus_s2_reg <= bus_s1_reg;
    end
  end
  logic talk_s, poll_s, taken_s, poll_d_reg;
  assign talk_s = bus_s2_reg[2];
  assign poll_s = bus_s2_reg[1];
  assign taken_s = bus_s2_reg[0];
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) poll_d_reg <= 1'b0;
    else poll_d_reg <= poll_s;
  end
  logic poll_end;
  // Clear on the end of the poll so the read byte is the pre-clear value
  assign poll_end = poll_d_reg & ~poll_s;

  logic [7:0] service_request_mask_reg, event_status_mask_reg;
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      service_request_mask_reg <= `SSR_ZERO_BYTE;
      event_status_mask_reg <= `SSR_ZERO_BYTE;
    end else begin
      if (sre_write_in) service_request_mask_reg <= wr_data_in;
      if (ese_write_in) event_status_mask_reg <= wr_data_in;
    end
  end

  // Event register; read of the event query clears, new events win
  logic esr_read;
  logic opc_armed_reg, pon_pend_reg;
  logic [7:0] event_status_latch_reg, esr_set;
  always_comb begin
    esr_set = `SSR_ZERO_BYTE;
    esr_set[`SSR_ESR_PON] = pon_pend_reg;
    esr_set[`SSR_ESR_CME] = cmd_error_in;
    esr_set[`SSR_ESR_EXE] = exec_error_in;
    esr_set[`SSR_ESR_QYE] = query_lost_in;
    esr_set[`SSR_ESR_OPC] = opc_armed_reg & ~ops_pending_in;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) pon_pend_reg <= 1'b1;
    else pon_pend_reg <= 1'b0;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) opc_armed_reg <= 1'b0;
    else if (opc_cmd_in) opc_armed_reg <= 1'b1;
    else if (!ops_pending_in) opc_armed_reg <= 1'b0;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) event_status_latch_reg <= `SSR_ZERO_BYTE;
    else if (esr_read)
      event_status_latch_reg <= esr_set & `SSR_ESR_USED_MASK;
    else
      event_status_latch_reg <= (event_status_latch_reg | esr_set)
                                & `SSR_ESR_USED_MASK;
  end

  // Status byte latches; serial poll end clears, set wins
  logic [7:0] stb_latch_reg, stb_set, service_status_summary;
  always_comb begin
    stb_set = `SSR_ZERO_BYTE;
    stb_set[`SSR_STB_RAMP] = ramp_done_in;
    stb_set[`SSR_STB_ERR] = |instr_error_in;
    stb_set[`SSR_STB_ALM] = alarm_in;
    stb_set[`SSR_STB_VALID] = valid_read_in;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) stb_latch_reg <= `SSR_ZERO_BYTE;
    else if (poll_end) stb_latch_reg <= stb_set;
    else stb_latch_reg <= stb_latch_reg | stb_set;
  end
  logic esb, enabled_any, srq_req;
  logic [7:0] report_bits;
  assign esb = |(event_status_latch_reg & event_status_mask_reg);
  always_comb begin
    report_bits = stb_latch_reg & `SSR_STB_LATCH_MASK;
    report_bits[`SSR_STB_ESB] = esb;
  end
  // Summary bit 6 is kept apart so the request never feeds back into itself
  always_comb begin
    service_status_summary = report_bits;
    service_status_summary[`SSR_STB_RQS] = srq_req;
  end
  // Mask bit 6 is the master enable, so it is kept out of the report set
  assign enabled_any = |(report_bits & service_request_mask_reg
                         & `SSR_STB_LATCH_MASK);
  assign srq_req = service_request_mask_reg[`SSR_STB_RQS] & enabled_any;

  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      srq_o_out <= 1'b1;
      srq_oe_n_out <= 1'b1;
    end else begin
      srq_o_out <= ~srq_req;
      srq_oe_n_out <= ~srq_req;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) poll_byte_out <= `SSR_ZERO_BYTE;
    else poll_byte_out <= service_status_summary;
  end

  // Query capture: a new query overwrites the pending one
  ssr_pkg::ssr_query_t pend_q_reg;
  logic [7:0] pend_data_reg;
  ssr_pkg::ssr_state_t state_reg;
  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pend_q_reg <= ssr_pkg::SSR_Q_NONE_E;
      pend_data_reg <= `SSR_ZERO_BYTE;
    end else if (query_valid_in) begin
      pend_q_reg <= ssr_pkg::ssr_query_t'(query_sel_in);
      pend_data_reg <= query_data_in;
    end else if (state_reg == ssr_pkg::SSR_ARMED && talk_s) begin
      pend_q_reg <= ssr_pkg::SSR_Q_NONE_E;
    end
  end

  function automatic logic [7:0] ssr_answer(input logic [2:0] q,
      input logic [7:0] stb, input logic [7:0] service_request_mask, input logic [7:0] event_status_latch,
      input logic [7:0] event_status_mask, input logic [7:0] dat);
    case (q)
      `SSR_Q_STB: ssr_answer = stb;
      `SSR_Q_SRE: ssr_answer = service_request_mask;
      `SSR_Q_ESR: ssr_answer = event_status_latch;
      `SSR_Q_ESE: ssr_answer = event_status_mask;
      `SSR_Q_DATA: ssr_answer = dat;
      default: ssr_answer = `SSR_ZERO_BYTE;
    endcase
  endfunction

  assign esr_read = state_reg == ssr_pkg::SSR_ARMED && talk_s
                    && !query_valid_in
                    && pend_q_reg == ssr_pkg::SSR_Q_ESR_E;

  always_ff @(posedge sys_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ssr_pkg::SSR_IDLE;
      resp_data_out <= `SSR_ZERO_BYTE;
    end else begin
      case (state_reg)
        ssr_pkg::SSR_IDLE: begin
          if (query_valid_in) state_reg <= ssr_pkg::SSR_ARMED;
        end
        ssr_pkg::SSR_ARMED: begin
          if (talk_s && !query_valid_in) begin
            state_reg <= ssr_pkg::SSR_SEND;
            // status byte read leaves its latches alone
            resp_data_out <= ssr_answer(pend_q_reg, service_status_summary,
                service_request_mask_reg, event_status_latch_reg,
                event_status_mask_reg, pend_data_reg);
          end
        end
        ssr_pkg::SSR_SEND: begin
          if (taken_s || !talk_s) state_reg <= ssr_pkg::SSR_IDLE;
        end
        default: state_reg <= ssr_pkg::SSR_IDLE;
      endcase
    end
  end
  assign resp_valid_out = state_reg == ssr_pkg::SSR_SEND && talk_s;

  chk_resp_only_talk: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg) resp_valid_out |-> talk_s)
    else $error("response while not talker");
  chk_srq_master_en: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    !service_request_mask_reg[`SSR_STB_RQS] |=> srq_oe_n_out)
    else $error("srq without mask bit 6");
  chk_srq_follows_req: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg) srq_req |=> !srq_oe_n_out && !srq_o_out)
    else $error("srq not driven low");
  chk_srq_release: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg) !srq_req |=> srq_oe_n_out)
    else $error("srq not released");
  chk_poll_clears: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    poll_end && stb_set == `SSR_ZERO_BYTE |=> stb_latch_reg == 8'h00)
    else $error("serial poll did not clear");
  chk_ramp_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ramp_done_in |=> service_status_summary[`SSR_STB_RAMP])
    else $error("ramp bit not set");
  chk_esr_unused: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    (event_status_latch_reg & ~`SSR_ESR_USED_MASK) == 8'h00)
    else $error("unused event bit set");
  chk_cme_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    cmd_error_in |=> event_status_latch_reg[`SSR_ESR_CME])
    else $error("command error not latched");
  chk_ese_load: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ese_write_in |=> event_status_mask_reg == $past(wr_data_in))
    else $error("enable mask not loaded");
  chk_stb_no_clear: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    !poll_end ##1 !poll_end |-> (stb_latch_reg & $past(stb_latch_reg))
      == $past(stb_latch_reg))
    else $error("status latch lost without poll");

  // Steps of the response and poll handshakes, and the event service request condition
  sequence ssr_armed_talk;
    state_reg == ssr_pkg::SSR_ARMED && talk_s && !query_valid_in;
  endsequence
  sequence ssr_send_done;
    state_reg == ssr_pkg::SSR_SEND && (taken_s || !talk_s);
  endsequence
  sequence ssr_poll_fall;
    poll_d_reg && !poll_s;
  endsequence
  sequence ssr_event_req;
    (|(event_status_latch_reg & event_status_mask_reg))
      && service_request_mask_reg[`SSR_STB_ESB]
      && service_request_mask_reg[`SSR_STB_RQS];
  endsequence

  chk_arm_send: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ssr_armed_talk |=> state_reg == ssr_pkg::SSR_SEND)
    else $error("armed talker did not send");
  chk_send_idle: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ssr_send_done |=> state_reg == ssr_pkg::SSR_IDLE)
    else $error("response did not end");
  chk_query_quiet: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    query_valid_in && !talk_s |=> !resp_valid_out)
    else $error("query started a response");
  chk_latest_query: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    query_valid_in |=> pend_q_reg == ssr_pkg::ssr_query_t'($past(query_sel_in)))
    else $error("latest query not kept");
  chk_stb_answer: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ssr_armed_talk ##0 (pend_q_reg == ssr_pkg::SSR_Q_STB_E)
      |=> resp_data_out == $past(service_status_summary))
    else $error("status byte answer wrong");
  chk_ese_answer: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ssr_armed_talk ##0 (pend_q_reg == ssr_pkg::SSR_Q_ESE_E)
      |=> resp_data_out == $past(event_status_mask_reg))
    else $error("enable mask answer wrong");
  chk_esr_read_clr: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    esr_read |=> event_status_latch_reg
      == ($past(esr_set) & `SSR_ESR_USED_MASK))
    else $error("event read did not clear");
  chk_poll_reload: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ssr_poll_fall |=> stb_latch_reg == $past(stb_set))
    else $error("poll end did not clear latches");
  chk_stb_unused: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    service_status_summary[1:0] == 2'b00)
    else $error("unused status bit set");
  chk_err_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    (|instr_error_in) |=> service_status_summary[`SSR_STB_ERR])
    else $error("error bit not set");
  chk_alarm_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    alarm_in |=> service_status_summary[`SSR_STB_ALM])
    else $error("alarm bit not set");
  chk_valid_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    valid_read_in |=> service_status_summary[`SSR_STB_VALID])
    else $error("valid reading bit not set");

  chk_exe_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    exec_error_in |=> event_status_latch_reg[`SSR_ESR_EXE])
    else $error("execution error not latched");
  chk_qye_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    query_lost_in |=> event_status_latch_reg[`SSR_ESR_QYE])
    else $error("query error not latched");
  chk_opc_sets: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    opc_armed_reg && !ops_pending_in |=> event_status_latch_reg[`SSR_ESR_OPC])
    else $error("operation complete not latched");
  chk_sre_load: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    sre_write_in |=> service_request_mask_reg == $past(wr_data_in))
    else $error("request mask not loaded");
  chk_poll_byte: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    1'b1 |=> poll_byte_out == $past(service_status_summary))
    else $error("poll byte does not follow status");
  chk_event_srq: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    ssr_event_req |=> !srq_oe_n_out && !srq_o_out)
    else $error("enabled event did not request");
  chk_srq_pin_pair: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_reg)
    srq_o_out == srq_oe_n_out)
    else $error("srq level and enable differ");
endmodule

// ===== bench/ssr_host.sv
`timescale 1ns/1ps
module ssr_host (
  // Clock and device answers
  input wire logic clk_in,
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_data_in,
  input wire logic [7:0] poll_byte_in,
  // Bus state toward the device
  output logic talk_addr_out,
  output logic serial_poll_out,
  output logic resp_taken_out
);
  initial begin
    talk_addr_out = 1'b0;
    serial_poll_out = 1'b0;
    resp_taken_out = 1'b0;
  end
  // Talker addressing is the only thing that may start a response
  task automatic talk(output logic [7:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_in) talk_addr_out <= 1'b1;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_in);
      if (resp_valid_in === 1'b1) begin
        ok = 1'b1;
        d = resp_data_in;
        resp_taken_out <= 1'b1;
      end
    end
    for (n = 0; n < 20 && resp_valid_in !== 1'b0; n++) begin
      @(posedge clk_in);
    end
    if (resp_valid_in !== 1'b0) ok = 1'b0;
    talk_addr_out <= 1'b0;
    resp_taken_out <= 1'b0;
    // Let the synchronised bus state fall back before the next request
    repeat (4) @(posedge clk_in);
  endtask
  // Poll byte is read while the poll stands; clearing follows its end
  task automatic poll(output logic [7:0] d);
    @(posedge clk_in) serial_poll_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    d = poll_byte_in;
    serial_poll_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// ===== bench/status_service_request_tb.sv
`timescale 1ns/1ps
module status_service_request_tb;
  logic sys_clk_in, nrst_in, sre_wr, ese_wr, qv, pend;
  logic talk, spoll, taken, rv, srq_o, srq_oe_n;
  logic [6:0] ev;
  logic [2:0] qsel;
  logic [7:0] err, wdat, qdat, rdata, pbyte, d;
  int failures, check_count, i;
  bit ok;
  ssr_status_service_request uut (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .ramp_done_in(ev[0]), .instr_error_in(err),
    .alarm_in(ev[1]), .valid_read_in(ev[2]), .cmd_error_in(ev[3]),
    .exec_error_in(ev[4]), .query_lost_in(ev[5]), .opc_cmd_in(ev[6]),
    .ops_pending_in(pend), .sre_write_in(sre_wr), .ese_write_in(ese_wr),
    .wr_data_in(wdat), .query_valid_in(qv), .query_sel_in(qsel),
    .query_data_in(qdat), .talk_addr_in(talk), .serial_poll_in(spoll),
    .resp_taken_in(taken), .resp_valid_out(rv), .resp_data_out(rdata),
    .poll_byte_out(pbyte), .srq_o_out(srq_o), .srq_oe_n_out(srq_oe_n));
  ssr_host host (.clk_in(sys_clk_in), .resp_valid_in(rv),
    .resp_data_in(rdata), .poll_byte_in(pbyte), .talk_addr_out(talk),
    .serial_poll_out(spoll), .resp_taken_out(taken));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic pulse(input logic [6:0] m, input logic [7:0] e);
    @(posedge sys_clk_in) ev <= m;
    err <= e;
    @(posedge sys_clk_in) ev <= 7'h00;
    err <= 8'h00;
    repeat (3) @(posedge sys_clk_in);
  endtask
  task automatic wr(input bit s, input logic [7:0] v);
    @(posedge sys_clk_in) sre_wr <= s;
    ese_wr <= !s;
    wdat <= v;
    @(posedge sys_clk_in) sre_wr <= 1'b0;
    ese_wr <= 1'b0;
  endtask
  task automatic q(input logic [2:0] s);
    @(posedge sys_clk_in) qv <= 1'b1;
    qsel <= s;
    @(posedge sys_clk_in) qv <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s);
    q(s);
    host.talk(d, ok);
    if (!ok) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic t_status();
    for (i = 0; i < 8; i++) begin
      pulse(7'h00, 8'h01 << i);
      rd(3'h1);
      check(d, 8'h10);
      host.poll(d);
      check(d, 8'h10);
    end
    pulse(7'h07, 8'h00);
    rd(3'h1);
    check(d, 8'h8c);
    rd(3'h1);
    check(d, 8'h8c);
    check({7'h00, srq_oe_n}, 8'h01);
    host.poll(d);
    check(d, 8'h8c);
    rd(3'h1);
    check(d, 8'h00);
  endtask
  task automatic t_srq();
    wr(1'b1, 8'h08);
    pulse(7'h02, 8'h00);
    check({7'h00, srq_oe_n}, 8'h01);
    rd(3'h2);
    check(d, 8'h08);
    wr(1'b1, 8'h48);
    repeat (3) @(posedge sys_clk_in);
    check({7'h00, srq_oe_n}, 8'h00);
    host.poll(d);
    check(d, 8'h48);
    repeat (2) @(posedge sys_clk_in);
    check({7'h00, srq_oe_n}, 8'h01);
    pulse(7'h04, 8'h00);
    check({7'h00, srq_oe_n}, 8'h01);
  endtask
  task automatic t_event();
    host.poll(d);
    wr(1'b0, 8'h10);
    wr(1'b1, 8'h40);
    pulse(7'h10, 8'h00);
    check({7'h00, srq_oe_n}, 8'h01);
    wr(1'b1, 8'h60);
    repeat (3) @(posedge sys_clk_in);
    check({7'h00, srq_oe_n}, 8'h00);
    rd(3'h1);
    check(d, 8'h60);
    rd(3'h4);
    check(d, 8'h10);
    pend <= 1'b1;
    pulse(7'h68, 8'h00);
    pend <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rd(3'h3);
    check(d, 8'h35);
  endtask
  task automatic t_query();
    q(3'h2);
    q(3'h4);
    host.talk(d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, 8'h10);
    q(3'h5);
    repeat (10) @(posedge sys_clk_in);
    check({7'h00, rv}, 8'h00);
    rd(3'h5);
    check(d, 8'ha5);
  endtask
  initial begin
    {nrst_in, sre_wr, ese_wr, qv, pend} = 5'h00;
    ev = 7'h00;
    qsel = 3'h0;
    err = 8'h00;
    wdat = 8'h00;
    qdat = 8'ha5;
    failures = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    rd(3'h3);
    check(d, 8'h80);
    rd(3'h3);
    check(d, 8'h00);
    t_status();
    t_srq();
    t_event();
    t_query();
    print_verdict();
  end
endmodule
